/* File: logic/ifs_pkg.sv */
package ifs_pkg;

  // Timebase
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned NS_PER_MS = 1000000;

  // Delays in their own units
  localparam int unsigned POR_PULSE_NS = 25000;
  localparam int unsigned VDD_GLITCH_NS = 5000;
  localparam int unsigned INTERNAL_SUPPLY_GLITCH_NS = 1000;
  localparam int unsigned UV_CLEAR_NS = 1000;
  localparam int unsigned DEBOUNCE_MS = 48;
  localparam int unsigned COOLDOWN_MS = 900;
  localparam int unsigned BREAKER_MS = 2;

  // Derived cycle counts; least times round up
  localparam int unsigned POR_CYC = (POR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned VDD_GLITCH_CYC = VDD_GLITCH_NS / CLK_PERIOD_NS;
  localparam int unsigned INTERNAL_SUPPLY_GLITCH_CYC = INTERNAL_SUPPLY_GLITCH_NS / CLK_PERIOD_NS;
  localparam int unsigned UV_CLEAR_CYC = (UV_CLEAR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DEBOUNCE_CYC =
    (DEBOUNCE_MS * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned COOLDOWN_CYC =
    (COOLDOWN_MS * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned BREAKER_CYC = (BREAKER_MS * NS_PER_MS) / CLK_PERIOD_NS;

  localparam int unsigned COOL_TIMER_CYCLES = 8;

  typedef enum logic [4:0] {
    ST_POR  = 5'b00001,
    ST_WAIT = 5'b00010,
    ST_ON   = 5'b00100,
    ST_COOL = 5'b01000,
    ST_FAST = 5'b10000
  } ifs_state_t;

  // Comparator results, all asynchronous to clk_sys
  typedef struct packed {
    logic vdd_lockout_ok;     // input supply above lockout
    logic vdd_fast_ok;        // input supply above fast-shutdown level
    logic internal_supply_por_ok;      // internal supply above power-on level
    logic internal_supply_min_ok;      // internal supply above fast-shutdown level
    logic undervoltage_ok;    // undervoltage_input above its threshold
    logic undervoltage_clear; // undervoltage_input below fault-clear level
    logic overvoltage;        // overvoltage_input above its threshold
    logic output_feedback_ok; // output_feedback above power-good level
    logic gate_overdrive_ok;  // gate minus output above good level
    logic current_limit;      // current amplifier is limiting
    logic timer_high;         // timer node above trip level
    logic timer_low;          // timer node below rearm level
    logic timer_strapped;     // timer node tied to internal_supply
    logic temp_hot;           // die above trip temperature
    logic temp_cool;          // die below release temperature
  } ifs_cmp_t;

  typedef struct packed {
    logic por_pulse;        // internal initialisation pulse
    logic gate_ramp;        // constant-slope inrush charge of the gate
    logic gate_pulldown;    // gate to ground, normal turn-off
    logic gate_fast_off;    // strong gate to output pull
    logic current_regulate; // enable the current-limit gate loop
    logic timer_charge;     // strong timer node pull-up
    logic timer_discharge;  // weak timer node pull-down
  } ifs_drive_t;

endpackage : ifs_pkg

/* File: logic/ifs_sequencer.sv */
// Operation
// - Supplies good issue reset pulse, clearing latches.
// - Turn-on needs all conditions stable for debounce.
// - Turn-on drives constant-slope gate ramp.
// - Power-good releases when feedback and overdrive good.
// - Undervoltage causes normal gate pull-down turn-off.
// - Overvoltage, breaker trip, overtemperature turn switch off.
// - Switch off pulls power-good output low.
// - Sustained supply dips start fast shutdown.
// - Overcurrent fault only after limit exceeds timeout.
// - Current limiting regulates gate at foldback threshold.
// - Limiting charges timer; trip turns switch off.
// - Strapped timer uses fixed internal breaker delay.
// - Breaker trip sets latch and drives fault output.
// - Eight timer cycles then debounce before retry.
// - Undervoltage low pulse clears latch; else latched.
// - Internal mode waits cool-down then debounce.
// - Fault wired to undervoltage gives periodic retry.
// - Overtemperature holds off until release temperature.
// - Overvoltage clearing restarts ramp without debounce.
module ifs_sequencer
  import ifs_pkg::*;
#(
  parameter int unsigned DEB_CYC = DEBOUNCE_CYC,
  parameter int unsigned COOL_CYC = COOLDOWN_CYC,
  parameter int unsigned BRK_CYC = BREAKER_CYC
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire ifs_cmp_t cmp_in,
  output ifs_drive_t drive_o,
  output logic power_good_output_oe,
  output logic fault_output_oe
);

  localparam int DW = $clog2(DEB_CYC + 1);
  localparam int CW = $clog2(COOL_CYC + 1);
  localparam int BW = $clog2(BRK_CYC + 1);
  localparam int PW = $clog2(POR_CYC + 1);
  localparam int GW = $clog2(VDD_GLITCH_CYC + 2);
  localparam int IW = $clog2(INTERNAL_SUPPLY_GLITCH_CYC + 2);
  localparam int UW = $clog2(UV_CLEAR_CYC + 1);
  localparam int NW = $clog2(COOL_TIMER_CYCLES + 1);

  ifs_cmp_t cmp_s1_r;
  ifs_cmp_t cmp_s2_r;
  ifs_state_t state_r;
  ifs_state_t state_nxt;
  ifs_drive_t drive_r;
  ifs_drive_t drive_nxt;
  logic [PW-1:0] por_cnt_r;
  logic [DW-1:0] deb_cnt_r;
  logic [CW-1:0] cool_cnt_r;
  logic [BW-1:0] brk_cnt_r;
  logic [GW-1:0] vdd_glt_r;
  logic [IW-1:0] icc_glt_r;
  logic [UW-1:0] uvclr_cnt_r;
  logic [NW-1:0] cyc_cnt_r;
  logic uvclr_armed_r;
  logic fault_latch_r;
  logic hot_r;
  logic ov_skip_r;
  logic cool_charging_r;
  logic pg_oe_r;
  logic flt_oe_r;
  logic sup_ok;
  logic fast_trip;
  logic conds_ok;
  logic deb_done;
  logic trip;
  logic cool_done;
  logic uv_clear_pulse;
  logic cycle_end;

  // Comparators are asynchronous; the first stage feeds only the second
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      cmp_s1_r <= '0;
      cmp_s2_r <= '0;
    end else begin
      cmp_s1_r <= cmp_in;
      cmp_s2_r <= cmp_s1_r;
    end
  end

  assign sup_ok = cmp_s2_r.vdd_lockout_ok && cmp_s2_r.internal_supply_por_ok;
  assign fast_trip = (vdd_glt_r == GW'(VDD_GLITCH_CYC + 1)) ||
                     (icc_glt_r == IW'(INTERNAL_SUPPLY_GLITCH_CYC + 1));
  assign conds_ok = cmp_s2_r.undervoltage_ok && !cmp_s2_r.overvoltage && !hot_r;
  assign deb_done = deb_cnt_r == DW'(DEB_CYC - 1);
  // External timer: node crosses high; strapped: fixed count while limiting
  assign trip = cmp_s2_r.current_limit &&
                (cmp_s2_r.timer_strapped ? (brk_cnt_r == BW'(BRK_CYC - 1))
                                         : cmp_s2_r.timer_high);
  assign cycle_end = !cool_charging_r && cmp_s2_r.timer_low;
  assign cool_done = cmp_s2_r.timer_strapped ? (cool_cnt_r == CW'(COOL_CYC - 1))
                   : (cycle_end && cyc_cnt_r == NW'(COOL_TIMER_CYCLES - 1));
  assign uv_clear_pulse = uvclr_armed_r && !cmp_s2_r.undervoltage_clear;

  // Dip filters: trip only after strictly longer than the allowed time
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      vdd_glt_r <= '0;
      icc_glt_r <= '0;
    end else begin
      if (cmp_s2_r.vdd_fast_ok) begin
        vdd_glt_r <= '0;
      end else if (vdd_glt_r != GW'(VDD_GLITCH_CYC + 1)) begin
        vdd_glt_r <= vdd_glt_r + GW'(1);
      end
      if (cmp_s2_r.internal_supply_min_ok) begin
        icc_glt_r <= '0;
      end else if (icc_glt_r != IW'(INTERNAL_SUPPLY_GLITCH_CYC + 1)) begin
        icc_glt_r <= icc_glt_r + IW'(1);
      end
    end
  end

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_POR: begin
        if (sup_ok && por_cnt_r == PW'(POR_CYC - 1)) begin
          state_nxt = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (conds_ok && !fault_latch_r && (ov_skip_r || deb_done)) begin
          state_nxt = ST_ON;
        end
      end
      ST_ON: begin
        if (!conds_ok) begin
          state_nxt = ST_WAIT;
        end else if (trip) begin
          state_nxt = ST_COOL;
        end
      end
      ST_COOL: begin
        if (cool_done) begin
          state_nxt = ST_WAIT;
        end
      end
      ST_FAST: begin
        if (cmp_s2_r.vdd_fast_ok && cmp_s2_r.internal_supply_min_ok) begin
          state_nxt = ST_POR;
        end
      end
      default: state_nxt = ST_POR;
    endcase
    if (state_r != ST_POR && state_r != ST_FAST) begin
      if (fast_trip) begin
        state_nxt = ST_FAST;
      end else if (!sup_ok) begin
        state_nxt = ST_POR;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state_r <= ST_POR;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      por_cnt_r <= '0;
    end else if (state_r != ST_POR || !sup_ok) begin
      por_cnt_r <= '0;
    end else if (por_cnt_r != PW'(POR_CYC - 1)) begin
      por_cnt_r <= por_cnt_r + PW'(1);
    end
  end

  // Debounce restarts on any interruption and only runs while waiting
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      deb_cnt_r <= '0;
    end else if (state_r != ST_WAIT || !conds_ok || !sup_ok) begin
      deb_cnt_r <= '0;
    end else if (!deb_done) begin
      deb_cnt_r <= deb_cnt_r + DW'(1);
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      brk_cnt_r <= '0;
    end else if (state_r != ST_ON || !cmp_s2_r.current_limit) begin
      brk_cnt_r <= '0;
    end else if (brk_cnt_r != BW'(BRK_CYC - 1)) begin
      brk_cnt_r <= brk_cnt_r + BW'(1);
    end
  end

  // Cool-down: strapped counts time, external counts node cycles
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      cool_cnt_r <= '0;
      cyc_cnt_r <= '0;
      cool_charging_r <= 1'b0;
    end else if (state_r != ST_COOL) begin
      cool_cnt_r <= '0;
      cyc_cnt_r <= '0;
      cool_charging_r <= 1'b0;
    end else begin
      if (!cool_done) begin
        cool_cnt_r <= cool_cnt_r + CW'(1);
      end
      if (cycle_end) begin
        cyc_cnt_r <= cyc_cnt_r + NW'(1);
        cool_charging_r <= 1'b1;
      end else if (cool_charging_r && cmp_s2_r.timer_high) begin
        cool_charging_r <= 1'b0;
      end
    end
  end

  // Clear needs the low level held, then acts on its release
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      uvclr_cnt_r <= '0;
      uvclr_armed_r <= 1'b0;
    end else if (!cmp_s2_r.undervoltage_clear) begin
      uvclr_cnt_r <= '0;
      uvclr_armed_r <= 1'b0;
    end else if (uvclr_cnt_r == UW'(UV_CLEAR_CYC - 1)) begin
      uvclr_armed_r <= 1'b1;
    end else begin
      uvclr_cnt_r <= uvclr_cnt_r + UW'(1);
    end
  end

  // A trip in the same cycle as a clear keeps the latch set
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      fault_latch_r <= 1'b0;
    end else if (state_r == ST_ON && state_nxt == ST_COOL) begin
      fault_latch_r <= 1'b1;
    end else if (state_r == ST_POR || uv_clear_pulse) begin
      fault_latch_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      hot_r <= 1'b0;
    end else if (cmp_s2_r.temp_hot) begin
      hot_r <= 1'b1;
    end else if (cmp_s2_r.temp_cool) begin
      hot_r <= 1'b0;
    end
  end

  // Skip debounce only when overvoltage alone caused the turn-off
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ov_skip_r <= 1'b0;
    end else if (state_r == ST_ON && state_nxt == ST_WAIT) begin
      ov_skip_r <= cmp_s2_r.overvoltage && cmp_s2_r.undervoltage_ok && !hot_r;
    end else if (state_r != ST_WAIT || !cmp_s2_r.undervoltage_ok || hot_r) begin
      ov_skip_r <= 1'b0;
    end
  end

  always_comb begin
    drive_nxt = '0;
    drive_nxt.por_pulse = state_r == ST_POR && sup_ok;
    drive_nxt.gate_ramp = state_r == ST_ON;
    drive_nxt.gate_pulldown = state_r == ST_WAIT || state_r == ST_COOL ||
                              state_r == ST_POR;
    drive_nxt.gate_fast_off = state_r == ST_FAST;
    // Foldback threshold itself is analog; logic only enables the loop
    drive_nxt.current_regulate = state_r == ST_ON && cmp_s2_r.current_limit;
    if (!cmp_s2_r.timer_strapped) begin
      drive_nxt.timer_charge = (state_r == ST_ON && cmp_s2_r.current_limit) ||
                               (state_r == ST_COOL && cool_charging_r);
      drive_nxt.timer_discharge = !drive_nxt.timer_charge;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      drive_r <= '0;
    end else begin
      drive_r <= drive_nxt;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      pg_oe_r <= 1'b1;
      flt_oe_r <= 1'b0;
    end else begin
      pg_oe_r <= !(state_r == ST_ON && cmp_s2_r.output_feedback_ok &&
                   cmp_s2_r.gate_overdrive_ok);
      // Released when cool-down ends, so a wired-back undervoltage input can rise
      flt_oe_r <= fault_latch_r && state_r == ST_COOL;
    end
  end

  assign drive_o = drive_r;
  assign power_good_output_oe = pg_oe_r;
  assign fault_output_oe = flt_oe_r;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  por_clears_latch_a: assert property (
    state_r == ST_POR |=> !fault_latch_r) else $error("latch not cleared by reset pulse");
  debounce_full_a: assert property (
    state_r == ST_WAIT && state_nxt == ST_ON && !ov_skip_r |-> deb_done && conds_ok)
    else $error("turn-on before debounce");
  ramp_on_a: assert property (
    state_r == ST_ON |=> drive_r.gate_ramp && !drive_r.gate_pulldown)
    else $error("gate ramp missing while on");
  pg_release_a: assert property (
    !power_good_output_oe |-> $past(state_r) == ST_ON &&
      $past(cmp_s2_r.output_feedback_ok) && $past(cmp_s2_r.gate_overdrive_ok))
    else $error("power good released without cause");
  uv_turnoff_a: assert property (
    state_r == ST_ON && !cmp_s2_r.undervoltage_ok && sup_ok && !fast_trip
      |=> state_r == ST_WAIT ##1 drive_r.gate_pulldown)
    else $error("undervoltage turn-off missing");
  fault_off_a: assert property (
    state_r == ST_ON && (cmp_s2_r.overvoltage || hot_r || trip) |=> state_r != ST_ON)
    else $error("fault did not turn off");
  pg_low_off_a: assert property (
    state_r != ST_ON |=> power_good_output_oe) else $error("power good not pulled low");
  fast_off_a: assert property (
    fast_trip && state_r inside {ST_WAIT, ST_ON, ST_COOL}
      |=> state_r == ST_FAST ##1 drive_r.gate_fast_off)
    else $error("fast shutdown missing");
  breaker_fault_a: assert property (
    state_r == ST_ON && state_nxt == ST_COOL |=> fault_latch_r ##1 fault_output_oe)
    else $error("trip without fault output");
  eight_cycles_a: assert property (
    state_r == ST_COOL && state_nxt == ST_WAIT && !cmp_s2_r.timer_strapped
      |-> cyc_cnt_r == NW'(COOL_TIMER_CYCLES - 1))
    else $error("cool-down cycle count wrong");
  latch_hold_a: assert property (
    fault_latch_r && !uv_clear_pulse && state_r != ST_POR |=> fault_latch_r)
    else $error("fault latch dropped without clear");
  flt_release_a: assert property (
    state_r != ST_COOL |=> !fault_output_oe) else $error("fault output held after cool-down");

  reach_on_c: cover property (state_r == ST_WAIT ##1 state_r == ST_ON);
  trip_c: cover property (state_r == ST_ON ##1 state_r == ST_COOL);
  clear_c: cover property (fault_latch_r ##1 !fault_latch_r);
  fast_c: cover property (state_r == ST_FAST);

endmodule : ifs_sequencer

/* File: verification/ifs_load_model.sv */
module ifs_load_model
  import ifs_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire ifs_drive_t drive_i,
  input wire logic strapped,
  output logic fb_ok,
  output logic overdrive_ok,
  output logic tmr_high,
  output logic tmr_low
);
  logic [3:0] gate_r;
  logic [3:0] node_r;

  // Coarse gate level; output follows gate once past half scale
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) gate_r <= 4'h0;
    else if (drive_i.gate_fast_off) gate_r <= 4'h0;
    else if (drive_i.gate_pulldown && gate_r != 4'h0) gate_r <= gate_r - 4'h1;
    else if (drive_i.gate_ramp && gate_r != 4'hf) gate_r <= gate_r + 4'h1;
  end

  // Timer node; one step per clock either way, enough to count cycles
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) node_r <= 4'h0;
    else if (drive_i.timer_charge && node_r != 4'hc) node_r <= node_r + 4'h1;
    else if (drive_i.timer_discharge && node_r != 4'h0) node_r <= node_r - 4'h1;
  end

  assign fb_ok = gate_r >= 4'h8;
  assign overdrive_ok = gate_r == 4'hf;
  // Strapped node sits at the internal supply level
  assign tmr_high = strapped | (node_r >= 4'ha);
  assign tmr_low = !strapped & (node_r <= 4'h2);
endmodule // ifs_load_model

/* File: verification/inrush_fault_sequencer_tb.sv */
module inrush_fault_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import ifs_pkg::*;
  localparam int DEB = 20;
  localparam int COOL = 30;
  localparam int BRK = 10;
  logic clk_sys, reset, auto_r, fb, od, th, tl, pg_oe, flt_oe;
  ifs_cmp_t cmp_r, cmp_in;
  ifs_drive_t drive_o;
  logic [8:0] mon;
  int failures, checks_done, lows, n;

  assign mon = {flt_oe, pg_oe, drive_o};

  always_comb begin
    cmp_in = cmp_r;
    cmp_in.output_feedback_ok = fb;
    cmp_in.gate_overdrive_ok = od;
    cmp_in.timer_high = th;
    cmp_in.timer_low = tl;
    if (auto_r) begin
      cmp_in.undervoltage_ok = !flt_oe;
      cmp_in.undervoltage_clear = flt_oe;
    end
  end

  always @(posedge tl) lows++;

  ifs_sequencer #(.DEB_CYC(DEB), .COOL_CYC(COOL), .BRK_CYC(BRK)) DUT (
    .clk_sys(clk_sys),
    .reset(reset),
    .cmp_in(cmp_in),
    .drive_o(drive_o),
    .power_good_output_oe(pg_oe),
    .fault_output_oe(flt_oe)
  );

  ifs_load_model load (
    .clk_sys(clk_sys),
    .reset(reset),
    .drive_i(drive_o),
    .strapped(cmp_r.timer_strapped),
    .fb_ok(fb),
    .overdrive_ok(od),
    .tmr_high(th),
    .tmr_low(tl)
  );

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic cyc(input int k);
    repeat (k) @(posedge clk_sys);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Out of range shows the count against the lower bound
  task automatic rng(input int got, input int lo, input int hi);
    chk((got >= lo && got <= hi) ? lo : got, lo);
  endtask

  task automatic wait_bit(input int idx, input logic val, input int maxc);
    n = 0;
    while (mon[idx] !== val && n < maxc) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
  endtask

  task automatic print_verdict;
    if (failures == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    cyc(20000);
    failures++;
    print_verdict;
  end

  initial begin
    failures = 0;
    checks_done = 0;
    lows = 0;
    auto_r = 1'b0;
    reset = 1'b1;
    cmp_r = '0;
    cmp_r.temp_cool = 1'b1;
    cmp_r.undervoltage_ok = 1'b1;
    cyc(4);
    #1;
    chk(mon, 9'h080);
    cyc(1);
    reset <= 1'b0;
    cyc(3);
    cmp_r <= ifs_cmp_t'(cmp_r | 15'h7800);
    wait_bit(6, 1'b1, 10);
    wait_bit(6, 1'b0, 700);
    rng(n, POR_CYC, POR_CYC + 1);
    // Bounce in mid-debounce must restart the whole wait
    cyc(5);
    cmp_r.undervoltage_ok <= 1'b0;
    cyc(5);
    cmp_r.undervoltage_ok <= 1'b1;
    wait_bit(5, 1'b1, 200);
    rng(n, DEB, DEB + 6);
    wait_bit(7, 1'b0, 60);
    chk(mon[7], 1'b0);
    cyc(1);
    cmp_r.undervoltage_ok <= 1'b0;
    wait_bit(4, 1'b1, 8);
    chk(mon[5:4], 2'b01);
    wait_bit(7, 1'b1, 40);
    chk(mon[7], 1'b1);
    cyc(1);
    cmp_r.undervoltage_ok <= 1'b1;
    wait_bit(5, 1'b1, DEB + 8);
    chk(mon[5], 1'b1);
    cyc(1);
    cmp_r.overvoltage <= 1'b1;
    wait_bit(5, 1'b0, 8);
    chk(mon[5:4], 2'b01);
    cyc(3);
    cmp_r.overvoltage <= 1'b0;
    wait_bit(5, 1'b1, 8);
    chk(mon[5], 1'b1);
    cyc(1);
    cmp_r.temp_hot <= 1'b1;
    cmp_r.temp_cool <= 1'b0;
    wait_bit(5, 1'b0, 8);
    chk(mon[5], 1'b0);
    cyc(3);
    cmp_r.temp_hot <= 1'b0;
    wait_bit(5, 1'b1, 3 * DEB);
    chk(mon[5], 1'b0);
    cyc(1);
    cmp_r.temp_cool <= 1'b1;
    wait_bit(5, 1'b1, DEB + 8);
    chk(mon[5], 1'b1);
    // External timer trip, latched off until cleared
    cyc(1);
    cmp_r.current_limit <= 1'b1;
    wait_bit(1, 1'b1, 8);
    chk(mon[2:1], 2'b11);
    wait_bit(8, 1'b1, 40);
    chk(mon[8], 1'b1);
    lows = 0;
    cyc(1);
    cmp_r.current_limit <= 1'b0;
    wait_bit(5, 1'b1, 400);
    chk(mon[5], 1'b0);
    chk(lows, 8);
    cyc(1);
    cmp_r.undervoltage_ok <= 1'b0;
    cmp_r.undervoltage_clear <= 1'b1;
    cyc(UV_CLEAR_CYC + 5);
    cmp_r.undervoltage_clear <= 1'b0;
    cmp_r.undervoltage_ok <= 1'b1;
    wait_bit(8, 1'b0, 10);
    chk(mon[8], 1'b0);
    wait_bit(5, 1'b1, DEB + 10);
    chk(mon[5], 1'b1);
    // Internal timer trip with fault wired back for retry
    cyc(1);
    cmp_r.timer_strapped <= 1'b1;
    cmp_r.current_limit <= 1'b1;
    wait_bit(8, 1'b1, BRK + 20);
    rng(n, BRK, BRK + 8);
    cyc(1);
    cmp_r.current_limit <= 1'b0;
    auto_r <= 1'b1;
    wait_bit(5, 1'b1, COOL + DEB + 80);
    rng(n, COOL + DEB - 2, COOL + DEB + 70);
    chk(mon[8], 1'b0);
    cyc(1);
    auto_r <= 1'b0;
    cmp_r.timer_strapped <= 1'b0;
    cmp_r.vdd_fast_ok <= 1'b0;
    wait_bit(3, 1'b1, 200);
    rng(n, 125, 132);
    cyc(1);
    cmp_r.vdd_fast_ok <= 1'b1;
    wait_bit(6, 1'b1, 10);
    chk(mon[6], 1'b1);
    print_verdict;
  end
endmodule // inrush_fault_sequencer_tb
